// File: rtl/pmc_pkg.sv
// constants and types shared by the power mode controller files.
// assumes a single system clock domain; oscillators and pins are async to it.
//
// Summary of operation
// - select 111 switches system clock to slow
// - slow switch waits for slow oscillator stable
// - select 000..110 returns fast, divide 1..64
// - fast switch waits for fast oscillator restart
// - halt with both keeps low enters sleep
// - halt keep hi0 lo1: low clock idle
// - halt keep hi1 lo1: both clock idle
// - halt keep hi1 lo0: high clock idle
// - halt stops execution, state held unchanged
// - halt sets power-down, clears timeout flag
// - halt clears watchdog counter
// - wake on port edge, interrupt, watchdog
// - power-up or clear-watchdog clears power-down flag
// - watchdog wake sets timeout, resets pc/sp only
// - per-pin port falling edge wake enable
// - disabled or stack-full interrupt resumes after halt
// - enabled interrupt with free stack: normal response
// - flag pending before halt cannot wake
// - select field is bits 7..5, 111 slow
// - fast stable flag clears, then sets when stable
// - sleep keeps slow oscillator only with watchdog

package pmc_pkg;

   // ---------------------------------------------------------------
   // field values and positions
   // ---------------------------------------------------------------
   localparam logic [2:0] SEL_LOW_SPEED = 3'h7; // slow source code
   localparam logic [2:0] SEL_RESET = 3'h0; // undivided fast clock
   localparam int SEL_MSB = 7; // select field top bit in control byte
   localparam int SEL_LSB = 5; // select field low bit in control byte
   localparam logic FLAG_RESET = 1'b0; // status flags after power-up
   localparam logic KEEP_RESET = 1'b0; // keep bits after power-up
   localparam int PORTA_WIDTH = 8; // port pins able to wake
   localparam int IRQ_WIDTH = 4; // interrupt request lines
   // cycles the fast oscillator must be enabled before its ready is trusted;
   // covers the synchroniser lag of a stale ready from the last run
   localparam logic [1:0] OSC_SETTLE_MIN = 2'h3;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sys_clk_select; // bits 7..5 of the clock control byte
      logic hi_osc_halt_keep; // fast oscillator stays on in halt
      logic lo_osc_halt_keep; // slow clock stays on in halt
   } pmc_clk_cfg_t;

   typedef struct packed {
      logic power_down_flag;
      logic watchdog_timeout_flag;
   } pmc_status_t;

   typedef struct packed {
      logic wake_porta;
      logic wake_irq;
      logic wake_wdt;
   } pmc_wake_t;

   typedef enum logic [5:0] {
      PMC_FAST = 6'h01, // running on divided fast clock
      PMC_SW_SLOW = 6'h02, // still fast, waiting on slow oscillator
      PMC_SLOW = 6'h04, // running on slow clock
      PMC_SW_FAST = 6'h08, // still slow, waiting on fast oscillator
      PMC_HALT = 6'h10, // sleep or one of the idle modes
      PMC_WAKE = 6'h20 // woken, waiting on the selected oscillator
   } pmc_state_t;

endpackage

// File: rtl/pmc_sync.sv
// two flip-flop synchroniser for a bus of independent levels.
// assumes each bit changes slowly against the clock; no word coherence.
`timescale 1ns/10ps

module pmc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta; // first stage, read only by q

   // --------------------------------------------------------------
   // two stage capture
   // --------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST;
         q <= RST;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

// File: rtl/power_mode_controller.sv
// operating mode controller: fast/slow clock switching, halt modes, wake-up.
// assumes cpu-side inputs are on clock; oscillator ready and port pins are async.
`timescale 1ns/10ps

module power_mode_controller #(
   parameter int PORTA_W = pmc_pkg::PORTA_WIDTH,
   parameter int IRQ_W = pmc_pkg::IRQ_WIDTH
) (
   input wire logic clock,
   input wire logic rstn,
   input wire pmc_pkg::pmc_clk_cfg_t clk_cfg,
   input wire logic hi_osc_enable,
   input wire logic halt_exec,
   input wire logic clr_wdt_exec,
   input wire logic wdt_enable,
   input wire logic wdt_overflow,
   input wire logic [IRQ_W-1:0] irq_flag,
   input wire logic [IRQ_W-1:0] irq_enable,
   input wire logic stack_full,
   input wire logic [PORTA_W-1:0] porta_pin,
   input wire logic [PORTA_W-1:0] porta_wake_enable,
   input wire logic hi_osc_ready,
   input wire logic lo_osc_ready,
   output pmc_pkg::pmc_state_t state,
   output logic cpu_run,
   output logic [2:0] sys_clk_div,
   output logic sys_clk_from_low,
   output logic hi_osc_run,
   output logic lo_osc_run,
   output logic sub_clk_run,
   output logic hi_osc_stable_flag,
   output pmc_pkg::pmc_status_t status,
   output logic wdt_clear,
   output logic pc_sp_reset,
   output logic irq_response,
   output logic resume_after_halt,
   output pmc_pkg::pmc_wake_t wake_cause
);

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_meta; // first reset stage
   logic rst_n; // released reset used everywhere

   // release is synchronous so no flop sees a runt recovery edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // async inputs
   // ---------------------------------------------------------------
   logic [PORTA_W+1:0] async_s; // synchronised pins and ready levels
   logic [PORTA_W-1:0] porta_s; // port pins after two flops
   logic hi_ready_s; // fast oscillator ready
   logic lo_ready_s; // slow oscillator ready

   // pins rest high (pulled up), ready levels rest low
   pmc_sync #(
      .W(PORTA_W + 2),
      .RST({{PORTA_W{1'b1}}, 2'b00})
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d({porta_pin, hi_osc_ready, lo_osc_ready}),
      .q(async_s)
   );

   assign porta_s = async_s[PORTA_W+1:2];
   assign hi_ready_s = async_s[1];
   assign lo_ready_s = async_s[0];

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   logic sel_low; // select asks for slow clock
   logic running; // cpu executing in this state
   logic halt_entry; // halt taken this cycle
   logic target_ready; // oscillator of the selected source is stable
   logic [PORTA_W-1:0] porta_prev; // last synchronised pin levels
   logic porta_fall; // enabled pin saw a falling edge
   logic [IRQ_W-1:0] irq_armed; // lines allowed to wake this halt
   logic irq_wake; // armed request raised
   logic wake_any; // any wake event
   logic irq_ok; // woken interrupt may be serviced now
   logic keep_hi; // fast oscillator keep, latched at halt
   logic keep_lo; // slow clock keep, latched at halt
   logic [1:0] hi_age; // cycles fast oscillator has been enabled
   pmc_pkg::pmc_state_t next_state;

   assign sel_low = (clk_cfg.sys_clk_select == pmc_pkg::SEL_LOW_SPEED);
   assign running = (state == pmc_pkg::PMC_FAST) || (state == pmc_pkg::PMC_SLOW) ||
                    (state == pmc_pkg::PMC_SW_SLOW) || (state == pmc_pkg::PMC_SW_FAST);
   assign halt_entry = running && halt_exec;
   assign target_ready = sel_low ? lo_ready_s : hi_osc_stable_flag;
   assign porta_fall = |(porta_prev & ~porta_s & porta_wake_enable);
   assign irq_wake = |(irq_flag & irq_armed);
   assign wake_any = porta_fall || irq_wake || wdt_overflow;
   assign irq_ok = (|(irq_flag & irq_armed & irq_enable)) && !stack_full;

   // ---------------------------------------------------------------
   // mode sequencing
   // ---------------------------------------------------------------
   // halt wins over a pending clock switch: the cpu stops either way
   always_comb begin
      next_state = state;
      case (state)
         pmc_pkg::PMC_FAST: begin
            if (halt_exec) begin
               next_state = pmc_pkg::PMC_HALT;
            end else if (sel_low) begin
               next_state = pmc_pkg::PMC_SW_SLOW;
            end
         end
         pmc_pkg::PMC_SW_SLOW: begin
            if (halt_exec) begin
               next_state = pmc_pkg::PMC_HALT;
            end else if (!sel_low) begin
               next_state = pmc_pkg::PMC_FAST; // aborted, fast still live
            end else if (lo_ready_s) begin
               next_state = pmc_pkg::PMC_SLOW;
            end
         end
         pmc_pkg::PMC_SLOW: begin
            if (halt_exec) begin
               next_state = pmc_pkg::PMC_HALT;
            end else if (!sel_low) begin
               next_state = pmc_pkg::PMC_SW_FAST;
            end
         end
         pmc_pkg::PMC_SW_FAST: begin
            if (halt_exec) begin
               next_state = pmc_pkg::PMC_HALT;
            end else if (sel_low) begin
               next_state = pmc_pkg::PMC_SW_SLOW;
            end else if (hi_osc_stable_flag) begin
               next_state = pmc_pkg::PMC_FAST;
            end
         end
         pmc_pkg::PMC_HALT: begin
            if (wake_any) begin
               next_state = pmc_pkg::PMC_WAKE;
            end
         end
         pmc_pkg::PMC_WAKE: begin
            if (target_ready) begin
               next_state = sel_low ? pmc_pkg::PMC_SLOW : pmc_pkg::PMC_FAST;
            end
         end
         default: begin
            next_state = pmc_pkg::PMC_FAST; // illegal code recovers to fast
         end
      endcase
   end

   // state register; execution stops while halted, nothing else is touched
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= pmc_pkg::PMC_FAST;
         cpu_run <= 1'b1;
      end else begin
         state <= next_state;
         cpu_run <= (next_state != pmc_pkg::PMC_HALT) && (next_state != pmc_pkg::PMC_WAKE);
      end
   end

   // ---------------------------------------------------------------
   // halt context
   // ---------------------------------------------------------------
   // keep bits and wake mask are frozen at halt entry; port history updates every cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         keep_hi <= pmc_pkg::KEEP_RESET;
         keep_lo <= pmc_pkg::KEEP_RESET;
         irq_armed <= '0;
         porta_prev <= '1;
      end else begin
         porta_prev <= porta_s;
         if (halt_entry) begin
            keep_hi <= clk_cfg.hi_osc_halt_keep;
            keep_lo <= clk_cfg.lo_osc_halt_keep;
            irq_armed <= ~irq_flag;
         end
      end
   end

   // ---------------------------------------------------------------
   // system clock selection
   // ---------------------------------------------------------------
   // divider only follows the field once the fast clock is in use
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sys_clk_div <= pmc_pkg::SEL_RESET;
         sys_clk_from_low <= 1'b0;
      end else if (next_state == pmc_pkg::PMC_FAST) begin
         sys_clk_div <= clk_cfg.sys_clk_select;
         sys_clk_from_low <= 1'b0;
      end else if (next_state == pmc_pkg::PMC_SLOW) begin
         sys_clk_from_low <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // oscillator and peripheral clock enables
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hi_osc_run <= 1'b1;
         lo_osc_run <= 1'b1;
         sub_clk_run <= 1'b1;
      end else begin
         case (next_state)
            pmc_pkg::PMC_HALT: begin
               // keep bits of an earlier halt must not leak into this entry
               hi_osc_run <= halt_entry ? clk_cfg.hi_osc_halt_keep : keep_hi;
               sub_clk_run <= halt_entry ? clk_cfg.lo_osc_halt_keep : keep_lo;
               // slow oscillator is dropped in sleep only when nothing counts on it
               if (halt_entry ? (clk_cfg.hi_osc_halt_keep | clk_cfg.lo_osc_halt_keep)
                              : (keep_hi | keep_lo)) begin
                  lo_osc_run <= 1'b1;
               end else begin
                  lo_osc_run <= wdt_enable;
               end
            end
            pmc_pkg::PMC_SLOW: begin
               hi_osc_run <= hi_osc_enable; // peripherals may still want it
               lo_osc_run <= 1'b1;
               sub_clk_run <= 1'b1;
            end
            pmc_pkg::PMC_WAKE: begin
               hi_osc_run <= !sel_low || hi_osc_enable;
               lo_osc_run <= 1'b1;
               sub_clk_run <= 1'b1;
            end
            default: begin
               hi_osc_run <= 1'b1; // fast and both switch states need it
               lo_osc_run <= 1'b1;
               sub_clk_run <= 1'b1;
            end
         endcase
      end
   end

   // stable flag: low while disabled, set only after the settle window
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hi_age <= 2'h0;
         hi_osc_stable_flag <= pmc_pkg::FLAG_RESET;
      end else if (!hi_osc_run) begin
         hi_age <= 2'h0;
         hi_osc_stable_flag <= 1'b0;
      end else begin
         if (hi_age != pmc_pkg::OSC_SETTLE_MIN) begin
            hi_age <= hi_age + 2'h1;
         end
         if (hi_age == pmc_pkg::OSC_SETTLE_MIN && hi_ready_s) begin
            hi_osc_stable_flag <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // status flags and watchdog clear
   // ---------------------------------------------------------------
   // set beats clear on every flag so no event is lost
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         status <= '{default: pmc_pkg::FLAG_RESET};
         wdt_clear <= 1'b0;
      end else begin
         wdt_clear <= halt_entry;
         if (halt_entry) begin
            status.power_down_flag <= 1'b1;
         end else if (clr_wdt_exec) begin
            status.power_down_flag <= 1'b0;
         end
         if (wdt_overflow) begin
            status.watchdog_timeout_flag <= 1'b1;
         end else if (halt_entry) begin
            status.watchdog_timeout_flag <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // wake cause and resume actions
   // ---------------------------------------------------------------
   // the resume pulse fires on the edge the cpu restarts
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_cause <= '0;
         pc_sp_reset <= 1'b0;
         irq_response <= 1'b0;
         resume_after_halt <= 1'b0;
      end else begin
         pc_sp_reset <= 1'b0;
         irq_response <= 1'b0;
         resume_after_halt <= 1'b0;
         if (state == pmc_pkg::PMC_HALT && wake_any) begin
            wake_cause <= '{wake_porta: porta_fall, wake_irq: irq_wake,
                            wake_wdt: wdt_overflow};
         end
         if (state == pmc_pkg::PMC_WAKE && target_ready) begin
            if (wake_cause.wake_wdt) begin
               pc_sp_reset <= 1'b1;
            end else if (wake_cause.wake_irq && irq_ok) begin
               irq_response <= 1'b1;
            end else begin
               resume_after_halt <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_slow_entry: assert property (
      state == pmc_pkg::PMC_SW_SLOW && sel_low && lo_ready_s && !halt_exec
      |=> state == pmc_pkg::PMC_SLOW ##1 sys_clk_from_low) else $error("slow switch missed");
   a_slow_waits_internal_slow_oscillator: assert property (
      state == pmc_pkg::PMC_SW_SLOW && !lo_ready_s |=> state != pmc_pkg::PMC_SLOW)
      else $error("slow entered before oscillator stable");
   a_fast_divider: assert property (
      state == pmc_pkg::PMC_FAST && !sel_low && !halt_exec
      |=> sys_clk_div == $past(clk_cfg.sys_clk_select) && !sys_clk_from_low)
      else $error("divider not following select");
   a_fast_waits_internal_fast_oscillator: assert property (
      state == pmc_pkg::PMC_FAST && $past(state) == pmc_pkg::PMC_SW_FAST
      |-> $past(hi_osc_stable_flag)) else $error("fast entered before stable");
   a_sleep_clocks: assert property (
      state == pmc_pkg::PMC_HALT && $past(state) == pmc_pkg::PMC_HALT && !keep_hi && !keep_lo
      |-> !hi_osc_run && !sub_clk_run && lo_osc_run == $past(wdt_enable))
      else $error("sleep clock gating wrong");
   a_idle_clocks: assert property (
      state == pmc_pkg::PMC_HALT && $past(state) == pmc_pkg::PMC_HALT && (keep_hi || keep_lo)
      |-> hi_osc_run == keep_hi && sub_clk_run == keep_lo && lo_osc_run)
      else $error("idle clock gating wrong");
   a_halt_stops_cpu: assert property (
      halt_entry && !wake_any |=> !cpu_run ##1 !cpu_run) else $error("cpu ran after halt");
   a_halt_flags: assert property (
      halt_entry && !wdt_overflow
      |=> status.power_down_flag && !status.watchdog_timeout_flag && wdt_clear)
      else $error("halt entry flags wrong");
   a_wake_event: assert property (
      state == pmc_pkg::PMC_HALT && wake_any |=> state == pmc_pkg::PMC_WAKE && !cpu_run)
      else $error("wake event ignored");
   a_pd_clear: assert property (
      clr_wdt_exec && !halt_entry |=> !status.power_down_flag) else $error("power-down not cleared");
   a_wdt_wake: assert property (
      state == pmc_pkg::PMC_HALT && wdt_overflow
      |=> status.watchdog_timeout_flag && wake_cause.wake_wdt) else $error("watchdog wake wrong");
   a_resume_kind: assert property (
      (irq_response || resume_after_halt) |-> !wake_cause.wake_wdt && !pc_sp_reset &&
      !(irq_response && resume_after_halt)) else $error("resume actions collide");
   a_stale_irq: assert property (
      state == pmc_pkg::PMC_HALT && !irq_wake && !porta_fall && !wdt_overflow
      |=> state == pmc_pkg::PMC_HALT) else $error("woke without armed source");
   a_irq_mask: assert property (
      halt_entry |=> (irq_armed & $past(irq_flag)) == '0)
      else $error("pending request left armed");
   a_stable_flag: assert property (
      !hi_osc_run |=> !hi_osc_stable_flag ##1 !hi_osc_stable_flag || hi_osc_run)
      else $error("stable flag set while disabled");
   a_wake_resume: assert property (
      state == pmc_pkg::PMC_WAKE && !target_ready |=> !cpu_run && state == pmc_pkg::PMC_WAKE)
      else $error("resumed before oscillator stable");

endmodule

// File: verif/tb_top.sv
// testbench for the power mode controller: clock switching, halt modes, wake-up.
// assumes the oscillators, pins and cpu-side pulses are all modelled here.
`timescale 1ns/10ps

module tb_top;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic clock, rstn, hi_osc_enable, halt_exec, clr_wdt_exec, wdt_enable, wdt_overflow;
   logic stack_full, hi_osc_ready, lo_osc_ready;
   pmc_pkg::pmc_clk_cfg_t clk_cfg;
   logic [3:0] irq_flag, irq_enable;
   logic [7:0] porta_pin, porta_wake_enable;
   pmc_pkg::pmc_state_t state;
   logic cpu_run, sys_clk_from_low, hi_osc_run, lo_osc_run, sub_clk_run, hi_osc_stable_flag;
   logic [2:0] sys_clk_div;
   pmc_pkg::pmc_status_t status;
   logic wdt_clear, pc_sp_reset, irq_response, resume_after_halt;
   pmc_pkg::pmc_wake_t wake_cause;
   int bad_count = 0; // mismatches seen
   int n_checks = 0; // comparisons made
   int k;

   power_mode_controller DUT (.clock(clock), .rstn(rstn), .clk_cfg(clk_cfg),
      .hi_osc_enable(hi_osc_enable), .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec),
      .wdt_enable(wdt_enable), .wdt_overflow(wdt_overflow), .irq_flag(irq_flag),
      .irq_enable(irq_enable), .stack_full(stack_full), .porta_pin(porta_pin),
      .porta_wake_enable(porta_wake_enable), .hi_osc_ready(hi_osc_ready),
      .lo_osc_ready(lo_osc_ready), .state(state), .cpu_run(cpu_run),
      .sys_clk_div(sys_clk_div), .sys_clk_from_low(sys_clk_from_low),
      .hi_osc_run(hi_osc_run), .lo_osc_run(lo_osc_run), .sub_clk_run(sub_clk_run),
      .hi_osc_stable_flag(hi_osc_stable_flag), .status(status), .wdt_clear(wdt_clear),
      .pc_sp_reset(pc_sp_reset), .irq_response(irq_response),
      .resume_after_halt(resume_after_halt), .wake_cause(wake_cause));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // 200 MHz system clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic give_verdict;
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask

   // settle one nanosecond past the edge so registered outputs have landed
   task automatic tick;
      @(posedge clock);
      #1;
   endtask

   // bounded wait; a hang ends the run through the verdict
   task automatic wait_state(input pmc_pkg::pmc_state_t s);
      for (int i = 0; i < 200; i++) begin
         if (state === s) return;
         tick;
      end
      check("state wait", 8'(s), 8'(state));
      give_verdict;
   endtask

   // one-cycle halt pulse, then the entry effects in the following cycle
   task automatic do_halt(input logic hk, input logic lk);
      @(posedge clock);
      clk_cfg <= {clk_cfg.sys_clk_select, hk, lk};
      halt_exec <= 1'b1;
      @(posedge clock);
      halt_exec <= 1'b0;
      #1;
      check("halt state", 8'(pmc_pkg::PMC_HALT), 8'(state));
      check("cpu_run", 8'h0, 8'(cpu_run));
      check("status", 8'h2, 8'(status));
      check("wdt_clear", 8'h1, 8'(wdt_clear));
      check("hi_run", 8'(hk), 8'(hi_osc_run));
      check("lo_run", 8'((hk | lk) ? 1'b1 : wdt_enable), 8'(lo_osc_run));
      check("sub_run", 8'(lk), 8'(sub_clk_run));
   endtask

   // wake completes when fast mode returns; pulses are seen in that cycle
   task automatic wait_wake(input logic [2:0] pulses, input logic [2:0] cause);
      wait_state(pmc_pkg::PMC_FAST);
      check("pulses", 8'(pulses), 8'({pc_sp_reset, irq_response, resume_after_halt}));
      check("wake_cause", 8'(cause), 8'(wake_cause));
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      clk_cfg = '0;
      hi_osc_enable = 1'b1;
      halt_exec = 1'b0;
      clr_wdt_exec = 1'b0;
      wdt_enable = 1'b0;
      wdt_overflow = 1'b0;
      irq_flag = 4'h0;
      irq_enable = 4'hf;
      stack_full = 1'b0;
      porta_pin = 8'hff;
      porta_wake_enable = 8'h01;
      hi_osc_ready = 1'b1;
      lo_osc_ready = 1'b1;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      for (k = 0; k < 40 && hi_osc_stable_flag !== 1'b1; k++) tick;
      check("stable", 8'h1, 8'(hi_osc_stable_flag));
      // slow switch must hold while the slow oscillator is not ready
      @(posedge clock);
      lo_osc_ready <= 1'b0;
      // let the stale ready drain through the synchroniser first
      repeat (3) @(posedge clock);
      clk_cfg <= {3'h7, 2'b00};
      repeat (6) tick;
      check("sw state", 8'(pmc_pkg::PMC_SW_SLOW), 8'(state));
      @(posedge clock);
      lo_osc_ready <= 1'b1;
      wait_state(pmc_pkg::PMC_SLOW);
      tick;
      check("from_low", 8'h1, 8'(sys_clk_from_low));
      // stop the fast oscillator, then return while it is not yet ready
      @(posedge clock);
      hi_osc_enable <= 1'b0;
      hi_osc_ready <= 1'b0;
      repeat (3) tick;
      check("stable", 8'h0, 8'(hi_osc_stable_flag));
      @(posedge clock);
      hi_osc_enable <= 1'b1;
      clk_cfg <= {3'h3, 2'b00};
      repeat (8) tick;
      check("sw state", 8'(pmc_pkg::PMC_SW_FAST), 8'(state));
      @(posedge clock);
      hi_osc_ready <= 1'b1;
      wait_state(pmc_pkg::PMC_FAST);
      check("div", 8'h3, 8'(sys_clk_div));
      check("from_low", 8'h0, 8'(sys_clk_from_low));
      for (k = 0; k < 7; k++) begin
         @(posedge clock);
         clk_cfg <= {k[2:0], 2'b00};
         repeat (2) tick;
         check("div", 8'(k), 8'(sys_clk_div));
      end
      // every halt mode; disabled pin must not wake, enabled pin must
      for (k = 0; k < 4; k++) begin
         do_halt(k[1], k[0]);
         @(posedge clock);
         porta_pin <= 8'hfd;
         repeat (8) tick;
         check("halted", 8'(pmc_pkg::PMC_HALT), 8'(state));
         @(posedge clock);
         porta_pin <= 8'hfc;
         wait_wake(3'b001, 3'b100);
         check("div kept", 8'h6, 8'(sys_clk_div));
         @(posedge clock);
         porta_pin <= 8'hff;
         repeat (6) tick;
      end
      @(posedge clock);
      clr_wdt_exec <= 1'b1;
      @(posedge clock);
      clr_wdt_exec <= 1'b0;
      tick;
      check("status", 8'h0, 8'(status));
      // watchdog wake from sleep with the watchdog running
      @(posedge clock);
      wdt_enable <= 1'b1;
      do_halt(1'b0, 1'b0);
      @(posedge clock);
      wdt_overflow <= 1'b1;
      @(posedge clock);
      wdt_overflow <= 1'b0;
      wait_wake(3'b100, 3'b001);
      check("status", 8'h3, 8'(status));
      // a flag pending at halt entry cannot wake; a fresh one can
      @(posedge clock);
      wdt_enable <= 1'b0;
      irq_flag <= 4'h2;
      do_halt(1'b1, 1'b1);
      repeat (8) tick;
      check("halted", 8'(pmc_pkg::PMC_HALT), 8'(state));
      @(posedge clock);
      irq_flag <= 4'h6;
      wait_wake(3'b010, 3'b010);
      // stack full, then interrupt disabled: both resume after the halt
      for (k = 0; k < 2; k++) begin
         @(posedge clock);
         irq_flag <= 4'h0;
         stack_full <= ~k[0];
         irq_enable <= k[0] ? 4'hb : 4'hf;
         do_halt(1'b1, 1'b1);
         @(posedge clock);
         irq_flag <= 4'h4;
         wait_wake(3'b001, 3'b010);
      end
      // idle taken from slow mode wakes back onto the slow oscillator
      @(posedge clock);
      clk_cfg <= {3'h7, 2'b00};
      wait_state(pmc_pkg::PMC_SLOW);
      do_halt(1'b0, 1'b1);
      @(posedge clock);
      irq_flag <= 4'h8;
      wait_state(pmc_pkg::PMC_SLOW);
      check("pulses", 8'h2, 8'({pc_sp_reset, irq_response, resume_after_halt}));
      check("from_low", 8'h1, 8'(sys_clk_from_low));
      give_verdict;
   end
endmodule
